// file: bench/adcr_ctrl_bench.sv
// Purpose: self-checking bench for the converter control register block
// Assumes: apb at word index * 4, analog core answered by the bench
// Notes: design assertions live in the design files
`timescale 1ns/100ps
`default_nettype none
module adcr_ctrl_bench;
  import adcr_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADCR_AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [8:0] trigger_in;
  logic dedicated_rc_clock = 1'b0;
  logic conv_enable;
  logic [5:0] conv_channel;
  logic conv_channel_valid;
  logic [1:0] conv_ref_sel;
  logic conv_ref_valid;
  logic conv_start;
  logic conv_clk_tick;
  logic conv_done = 1'b0;
  logic [9:0] conv_data;
  logic irq;
  int n_fail = 0;
  int samples_checked = 0;
  int n_start = 0;
  int core_cnt = 0;
  int exp_start;
  int n_tick = 0;
  int exp_tick;

  adcr_ctrl #(.TRIG_N(9)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trigger_in(trigger_in), .dedicated_rc_clock(dedicated_rc_clock),
    .conv_enable(conv_enable), .conv_channel(conv_channel), .conv_channel_valid(conv_channel_valid),
    .conv_ref_sel(conv_ref_sel), .conv_ref_valid(conv_ref_valid), .conv_start(conv_start),
    .conv_clk_tick(conv_clk_tick), .conv_done(conv_done), .conv_data(conv_data), .irq(irq));

  always #4 pclk = ~pclk;
  always #37 dedicated_rc_clock = ~dedicated_rc_clock;

  // analog core stand-in: answers each start after twelve cycles
  always @(posedge pclk) begin
    if (conv_start === 1'b1) begin
      n_start <= n_start + 1;
      core_cnt <= 12;
    end else if (core_cnt != 0) begin
      core_cnt <= core_cnt - 1;
    end
    conv_done <= (core_cnt == 1) && (conv_start !== 1'b1);
  end

  // conversion clock enables seen by the core
  always @(posedge pclk) begin
    if (conv_clk_tick === 1'b1) begin
      n_tick <= n_tick + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, idx, 8'h00, q, e);
    chk(q, {24'h000000, exp});
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (conv_done !== 1'b1 && n < 100);
    if (n >= 100) chk(32'h0, 32'h1);
    repeat (2) @(posedge pclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end

  initial begin
    logic [31:0] q;
    logic e;
    logic [9:0] idx_list [7];
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    trigger_in = 9'h000;
    conv_data = 10'h000;
    idx_list = '{IDX_CTRL0, IDX_CTRL1, IDX_TRIG, IDX_RES_LOW, IDX_RES_HIGH, IDX_INT_STAT, IDX_INT_MASK};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (idx_list[i]) rd_chk(idx_list[i], 8'h00);
    apb(1'b0, 10'h0A2, 8'h00, q, e);
    chk({31'h0, e}, 32'h1);
    // write without byte lane zero is ignored
    pstrb <= 4'h0;
    wr(IDX_INT_MASK, 8'hFF);
    pstrb <= 4'hF;
    rd_chk(IDX_INT_MASK, 8'h00);
    $display("test reset values done");
    for (int p = 0; p < 4; p++) begin
      wr(IDX_CTRL1, {1'b1, 3'(p + 4), 2'b00, 2'(p)});
      rd_chk(IDX_CTRL1, {1'b1, 3'(p + 4), 2'b00, 2'(p)});
      chk({28'h0, conv_ref_sel, 1'b0, conv_ref_valid}, {28'h0, 2'(p), 1'b0, p != 1});
    end
    wr(IDX_CTRL1, {1'b1, CS_RC_A, 2'b00, REF_SUPPLY});
    $display("test control one done");
    wr(IDX_CTRL0, {CHAN_FIXED_REF, 2'b00});
    chk({24'h0, conv_channel_valid, conv_enable, conv_channel}, {24'h0, 2'b10, CHAN_FIXED_REF});
    wr(IDX_CTRL0, {6'h1F, 2'b00});
    chk({24'h0, conv_channel_valid, 1'b0, conv_channel}, 32'h0);
    wr(IDX_CTRL0, {CHAN_GROUND, 2'b11});
    repeat (20) @(posedge pclk);
    chk(n_start, 0);
    rd_chk(IDX_CTRL0, {CHAN_GROUND, 2'b01});
    chk({31'h0, conv_enable}, 32'h1);
    $display("test channel and enable done");
    wr(IDX_INT_MASK, 8'h01);
    conv_data <= 10'h2A5;
    wr(IDX_CTRL0, {CHAN_GROUND, 2'b11});
    rd_chk(IDX_CTRL0, {CHAN_GROUND, 2'b11});
    wait_done();
    rd_chk(IDX_CTRL0, {CHAN_GROUND, 2'b01});
    rd_chk(IDX_RES_HIGH, 8'h02);
    rd_chk(IDX_RES_LOW, 8'hA5);
    rd_chk(IDX_INT_STAT, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_INT_STAT, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_CTRL1, {1'b0, CS_OSC_2, 2'b00, REF_SUPPLY});
    // fourteen busy pclk cycles at divide by two give seven enables
    exp_tick = n_tick + 7;
    wr(IDX_CTRL0, {CHAN_GROUND, 2'b11});
    wait_done();
    chk(n_tick, exp_tick);
    rd_chk(IDX_RES_HIGH, 8'hA9);
    rd_chk(IDX_RES_LOW, 8'h40);
    wr(IDX_INT_STAT, 8'h01);
    $display("test software conversion done");
    exp_start = n_start;
    for (int k = 1; k <= 9; k++) begin
      wr(IDX_TRIG, 8'(k));
      trigger_in[k - 1] <= 1'b1;
      wait_done();
      trigger_in <= 9'h000;
      exp_start++;
      chk(n_start, exp_start);
      repeat (6) @(posedge pclk);
    end
    foreach (idx_list[i]) begin
      wr(IDX_TRIG, (i == 0) ? 8'h00 : 8'(4'hA + i - 1));
      trigger_in <= 9'h1FF;
      repeat (20) @(posedge pclk);
      trigger_in <= 9'h000;
      repeat (6) @(posedge pclk);
      chk(n_start, exp_start);
    end
    $display("test trigger sources done");
    wr(IDX_INT_MASK, 8'h00);
    wr(IDX_INT_STAT, 8'h03);
    wr(IDX_TRIG, {4'h0, TRG_RES_READ});
    rd_chk(IDX_RES_HIGH, 8'hA9);
    wait_done();
    chk(n_start, exp_start + 1);
    rd_chk(IDX_INT_STAT, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_INT_STAT, 8'h01);
    rd_chk(IDX_INT_STAT, 8'h00);
    $display("test read trigger and masking done");
    wrap_up();
  end
endmodule
`default_nettype wire

// file: design/adcr_clk_div.sv
// Purpose: conversion clock enable from pclk divider or the dedicated rc clock
// Assumes: rc clock is slow against pclk
// Notes: tick only in the cycle after run was high
`timescale 1ns/100ps
`default_nettype none
module adcr_clk_div import adcr_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // dedicated rc clock pin
  input wire logic dedicated_rc_clock,
  // control side
  adcr_clk_if.div cif
);
  logic [5:0] cnt_reg;
  logic [2:0] rc_sync_reg;
  logic rc_level_reg;
  logic tick_reg;
  logic is_rc;
  logic [5:0] last;

  function automatic logic [5:0] div_last(input logic [2:0] sel);
    case (sel)
      CS_OSC_2: div_last = 6'h01;
      CS_OSC_4: div_last = 6'h03;
      CS_OSC_8: div_last = 6'h07;
      CS_OSC_16: div_last = 6'h0F;
      CS_OSC_32: div_last = 6'h1F;
      CS_OSC_64: div_last = 6'h3F;
      default: div_last = 6'h00;
    endcase
  endfunction

  assign is_rc = (cif.clk_sel == CS_RC_A) || (cif.clk_sel == CS_RC_B);
  assign last = div_last(cif.clk_sel);
  assign cif.tick = tick_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rc_sync_reg <= 3'h0;
      rc_level_reg <= 1'b0;
    end else begin
      rc_sync_reg <= {rc_sync_reg[1:0], dedicated_rc_clock};
      if (rc_sync_reg[2] == rc_sync_reg[1]) begin
        rc_level_reg <= rc_sync_reg[1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else if (!cif.run) begin
      cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else if (is_rc) begin
      tick_reg <= (rc_sync_reg[2] == rc_sync_reg[1]) && rc_sync_reg[1] && !rc_level_reg;
    end else if (cnt_reg >= last) begin
      cnt_reg <= 6'h00;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 6'h01;
      tick_reg <= 1'b0;
    end
  end

  chk_div_by_two: assert property (@(posedge pclk) disable iff (!presetn)
    (tick_reg && cif.run && cif.clk_sel == CS_OSC_2) ##1 (cif.run && cif.clk_sel == CS_OSC_2)
    |-> !tick_reg ##1 (tick_reg || !cif.run || cif.clk_sel != CS_OSC_2))
    else $error("divide by two tick spacing wrong");
endmodule
`default_nettype wire

// file: design/adcr_clk_if.sv
// Purpose: conversion clock request and tick between control and divider
// Assumes: both ends on pclk
// Notes: tick is a one-cycle enable
`timescale 1ns/100ps
`default_nettype none
interface adcr_clk_if;
  logic [2:0] clk_sel;
  logic run;
  logic tick;
  modport ctl (output clk_sel, output run, input tick);
  modport div (input clk_sel, input run, output tick);
endinterface
`default_nettype wire

// file: design/adcr_ctrl.sv
// Purpose: control, trigger and result registers of a 10-bit converter
// Assumes: analog core runs on pclk and pulses conv_done with data
// Notes: registers on apb at word index * 4, one wait state per access
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
//
// Overview of operation
// - six-bit channel field picks pin, fixed reference buffer or ground
// - writing go starts a conversion; go reads one while converting
// - hardware clears go when conversion ends; zero means idle
// - enable bit on powers the converter; off disables it
// - format set: result right-justified, top six bits zero
// - format clear: result left-justified, bottom six bits zero
// - three-bit clock field picks oscillator divisor or rc clock
// - two-bit reference field picks supply, external pin or fixed reference
// - four-bit trigger field picks auto-conversion source, zero disables
// - trigger code 1101: reading the high result byte triggers
// - result is two separately addressed bytes, high and low
// - rising edge on selected trigger sets go by hardware
// - completion clears go, sets done flag, stores the result
module adcr_ctrl import adcr_pkg::*; #(
  parameter int TRIG_N = TRG_SRCS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADCR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // trigger sources and rc clock pin
  input wire logic [TRIG_N-1:0] trigger_in,
  input wire logic dedicated_rc_clock,
  // analog core
  output logic conv_enable,
  output logic [5:0] conv_channel,
  output logic conv_channel_valid,
  output logic [1:0] conv_ref_sel,
  output logic conv_ref_valid,
  output logic conv_start,
  output logic conv_clk_tick,
  input wire logic conv_done,
  input wire logic [9:0] conv_data,
  // interrupt
  output logic irq
);
  adcr_clk_if cif ();
  adcr_state_e state_reg;
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [3:0] trig_sel_reg;
  logic [15:0] result_reg;
  logic [7:0] int_stat_reg;
  logic [7:0] int_mask_reg;
  logic ack_reg;
  logic [31:0] prdata_reg;
  logic slverr_reg;
  logic [TRIG_N-1:0] s1_reg;
  logic [TRIG_N-1:0] s2_reg;
  logic [TRIG_N-1:0] s3_reg;
  logic [TRIG_N-1:0] filt_reg;
  logic [TRIG_N-1:0] edge_reg;
  logic [9:0] idx;
  logic hit;
  logic acc_done;
  logic wr_en;
  logic rd_done;
  logic on_bit;
  logic go_bit;
  logic [5:0] input_channel_select;
  logic result_format_select;
  logic sw_start;
  logic hw_trig;
  logic sel_edge;
  logic res_read_trig;
  logic start_req;
  logic abort;
  logic done_evt;
  logic ovr_evt;
  logic [7:0] int_set;
  logic [7:0] int_clr;
  logic [7:0] rd_mux;

  function automatic logic chan_ok(input logic [5:0] c);
    case (c)
      6'h00, 6'h01, 6'h02, 6'h04, 6'h05: chan_ok = 1'b1;
      6'h0D, 6'h0E, 6'h0F: chan_ok = 1'b1;
      6'h12, 6'h13, 6'h14, 6'h15: chan_ok = 1'b1;
      CHAN_GROUND, CHAN_FIXED_REF: chan_ok = 1'b1;
      default: chan_ok = 1'b0;
    endcase
  endfunction

  function automatic logic is_reg(input logic [9:0] i, input logic [9:0] r);
    is_reg = (i == r);
  endfunction

  // bus decode
  assign idx = paddr[ADCR_AW-1:2];
  assign hit = (paddr[1:0] == 2'h0) && (is_reg(idx, IDX_RES_LOW) || is_reg(idx, IDX_RES_HIGH)
    || is_reg(idx, IDX_CTRL0) || is_reg(idx, IDX_CTRL1) || is_reg(idx, IDX_TRIG)
    || is_reg(idx, IDX_INT_STAT) || is_reg(idx, IDX_INT_MASK));
  assign acc_done = psel && penable && ack_reg;
  assign wr_en = acc_done && pwrite && hit && pstrb[0];
  assign rd_done = acc_done && !pwrite && hit;
  assign pready = acc_done;
  assign prdata = prdata_reg;
  assign pslverr = acc_done && slverr_reg;

  // field views
  assign on_bit = ctrl0_reg[CTRL0_ON_BIT];
  assign go_bit = (state_reg != ST_IDLE);
  assign input_channel_select = ctrl0_reg[7:CTRL0_CHAN_LSB];
  assign result_format_select = ctrl1_reg[CTRL1_FORMAT_BIT];

  // analog side
  assign conv_enable = on_bit;
  assign conv_channel_valid = chan_ok(input_channel_select);
  assign conv_channel = conv_channel_valid ? input_channel_select : 6'h00;
  assign conv_ref_sel = ctrl1_reg[CTRL1_REF_LSB+1:CTRL1_REF_LSB];
  assign conv_ref_valid = (conv_ref_sel != REF_RSVD);
  assign conv_start = (state_reg == ST_START);
  assign conv_clk_tick = cif.tick;
  assign cif.clk_sel = ctrl1_reg[CTRL1_CS_LSB+2:CTRL1_CS_LSB];
  assign cif.run = on_bit && go_bit;

  adcr_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .dedicated_rc_clock(dedicated_rc_clock),
    .cif(cif)
  );

  // apb one wait state, registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg;
      if (psel && penable && !ack_reg) begin
        prdata_reg <= {24'h00_0000, rd_mux};
        slverr_reg <= !hit;
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    if (hit && !pwrite) begin
      case (idx)
        IDX_RES_LOW: rd_mux = result_reg[7:0];
        IDX_RES_HIGH: rd_mux = result_reg[15:8];
        IDX_CTRL0: rd_mux = {input_channel_select, go_bit, on_bit};
        IDX_CTRL1: rd_mux = ctrl1_reg;
        IDX_TRIG: rd_mux = {4'h0, trig_sel_reg};
        IDX_INT_STAT: rd_mux = int_stat_reg;
        IDX_INT_MASK: rd_mux = int_mask_reg;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // trigger pins: three stages, change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= trigger_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < TRIG_N; g++) begin : g_trig
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          filt_reg[g] <= 1'b0;
          edge_reg[g] <= 1'b0;
        end else begin
          if (s2_reg[g] == s3_reg[g]) begin
            filt_reg[g] <= s3_reg[g];
          end
          edge_reg[g] <= (s2_reg[g] == s3_reg[g]) && s3_reg[g] && !filt_reg[g];
        end
      end
    end
  endgenerate

  // start and abort conditions
  always_comb begin
    sel_edge = 1'b0;
    if (trig_sel_reg != TRG_OFF && trig_sel_reg <= TRG_LAST_SRC) begin
      sel_edge = edge_reg[trig_sel_reg - 4'h1];
    end
  end

  assign res_read_trig = rd_done && is_reg(idx, IDX_RES_HIGH) && (trig_sel_reg == TRG_RES_READ);
  assign hw_trig = on_bit && (sel_edge || res_read_trig);
  // go in the same write that turns the converter on is not honoured
  assign sw_start = wr_en && is_reg(idx, IDX_CTRL0) && pwdata[CTRL0_GO_BIT]
    && pwdata[CTRL0_ON_BIT] && on_bit;
  assign start_req = sw_start || hw_trig;
  assign abort = (state_reg != ST_IDLE) && wr_en && is_reg(idx, IDX_CTRL0)
    && (!pwdata[CTRL0_ON_BIT] || !pwdata[CTRL0_GO_BIT]);
  assign done_evt = (state_reg == ST_CONV) && conv_done && !abort;
  assign ovr_evt = hw_trig && (state_reg != ST_IDLE);

  // conversion sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          state_reg <= abort ? ST_IDLE : ST_CONV;
        end
        ST_CONV: begin
          if (abort || conv_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= CTRL0_RST;
      ctrl1_reg <= CTRL1_RST;
      trig_sel_reg <= TRIG_RST[3:0];
      int_mask_reg <= INT_MASK_RST;
    end else if (wr_en) begin
      if (is_reg(idx, IDX_CTRL0)) begin
        ctrl0_reg <= {pwdata[7:CTRL0_CHAN_LSB], 1'b0, pwdata[CTRL0_ON_BIT]};
      end
      if (is_reg(idx, IDX_CTRL1)) begin
        ctrl1_reg <= {pwdata[7:4], 2'h0, pwdata[1:0]};
      end
      if (is_reg(idx, IDX_TRIG)) begin
        trig_sel_reg <= pwdata[3:0];
      end
      if (is_reg(idx, IDX_INT_MASK)) begin
        int_mask_reg <= pwdata[7:0];
      end
    end
  end

  // result: completion wins over a software byte write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= RESULT_RST;
    end else if (done_evt) begin
      if (result_format_select) begin
        result_reg <= {6'h00, conv_data};
      end else begin
        result_reg <= {conv_data, 6'h00};
      end
    end else if (wr_en && is_reg(idx, IDX_RES_LOW)) begin
      result_reg[7:0] <= pwdata[7:0];
    end else if (wr_en && is_reg(idx, IDX_RES_HIGH)) begin
      result_reg[15:8] <= pwdata[7:0];
    end
  end

  // sticky status, write one to clear, set wins
  always_comb begin
    int_set = 8'h00;
    int_set[INT_DONE_BIT] = done_evt;
    int_set[INT_OVR_BIT] = ovr_evt;
    int_clr = (wr_en && is_reg(idx, IDX_INT_STAT)) ? pwdata[7:0] : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= 8'h00;
    end else begin
      int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
    end
  end

  assign irq = |(int_stat_reg & int_mask_reg);

  chk_sw_go_start: assert property (@(posedge pclk) disable iff (!presetn)
    (sw_start && state_reg == ST_IDLE) |=> (go_bit && conv_start) ##1 (go_bit && !conv_start))
    else $error("software go did not start a conversion");

  chk_go_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    (state_reg == ST_CONV && conv_done) |=> !go_bit && !conv_start)
    else $error("go not cleared at completion");

  chk_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt |=> int_stat_reg[INT_DONE_BIT])
    else $error("done flag not set at completion");

  chk_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (!on_bit && state_reg == ST_IDLE) |=> !go_bit)
    else $error("conversion started while converter off");

  chk_right_just: assert property (@(posedge pclk) disable iff (!presetn)
    (done_evt && result_format_select) |=> result_reg == {6'h00, $past(conv_data)})
    else $error("right justified result wrong");

  chk_left_just: assert property (@(posedge pclk) disable iff (!presetn)
    (done_evt && !result_format_select) |=> result_reg == {$past(conv_data), 6'h00})
    else $error("left justified result wrong");

  chk_read_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    (res_read_trig && on_bit && state_reg == ST_IDLE) |=> conv_start)
    else $error("high byte read did not trigger");

  chk_edge_trigger: assert property (@(posedge pclk) disable iff (!presetn)
    (sel_edge && on_bit && state_reg == ST_IDLE) |=> go_bit ##1 go_bit)
    else $error("trigger edge did not set go");

  chk_rsvd_channel: assert property (@(posedge pclk) disable iff (!presetn)
    !chan_ok(input_channel_select) |-> !conv_channel_valid && conv_channel == 6'h00)
    else $error("reserved channel connected an input");

  chk_enable_go: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && is_reg(idx, IDX_CTRL0) && !on_bit && state_reg == ST_IDLE && !hw_trig) |=> !go_bit)
    else $error("go honoured in enabling write");

  chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (done_evt && int_mask_reg[INT_DONE_BIT] && !(wr_en && is_reg(idx, IDX_INT_MASK))) |=> irq)
    else $error("interrupt output wrong");
endmodule
`default_nettype wire

// file: design/adcr_pkg.sv
// Purpose: constants for the converter control register block
// Assumes: registers sit at word index * 4 on the bus
// Notes: index 0x09C is the high result byte
package adcr_pkg;
  localparam int ADCR_AW = 12;
  // register word indices
  localparam logic [9:0] IDX_RES_LOW = 10'h09B;
  localparam logic [9:0] IDX_RES_HIGH = 10'h09C;
  localparam logic [9:0] IDX_CTRL0 = 10'h09D;
  localparam logic [9:0] IDX_CTRL1 = 10'h09E;
  localparam logic [9:0] IDX_TRIG = 10'h09F;
  localparam logic [9:0] IDX_INT_STAT = 10'h0A0;
  localparam logic [9:0] IDX_INT_MASK = 10'h0A1;
  // field positions
  localparam int CTRL0_ON_BIT = 0;
  localparam int CTRL0_GO_BIT = 1;
  localparam int CTRL0_CHAN_LSB = 2;
  localparam int CTRL1_REF_LSB = 0;
  localparam int CTRL1_CS_LSB = 4;
  localparam int CTRL1_FORMAT_BIT = 7;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_OVR_BIT = 1;
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] TRIG_RST = 8'h00;
  localparam logic [7:0] INT_MASK_RST = 8'h00;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  // conversion clock codes
  localparam logic [2:0] CS_OSC_2 = 3'h0;
  localparam logic [2:0] CS_OSC_8 = 3'h1;
  localparam logic [2:0] CS_OSC_32 = 3'h2;
  localparam logic [2:0] CS_RC_A = 3'h3;
  localparam logic [2:0] CS_OSC_4 = 3'h4;
  localparam logic [2:0] CS_OSC_16 = 3'h5;
  localparam logic [2:0] CS_OSC_64 = 3'h6;
  localparam logic [2:0] CS_RC_B = 3'h7;
  // positive reference codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_RSVD = 2'h1;
  localparam logic [1:0] REF_EXT_PIN = 2'h2;
  localparam logic [1:0] REF_FIXED = 2'h3;
  // channel codes beyond the port pins
  localparam logic [5:0] CHAN_GROUND = 6'h1B;
  localparam logic [5:0] CHAN_FIXED_REF = 6'h1E;
  // trigger codes
  localparam logic [3:0] TRG_OFF = 4'h0;
  localparam logic [3:0] TRG_LAST_SRC = 4'h9;
  localparam logic [3:0] TRG_RES_READ = 4'hD;
  localparam int TRG_SRCS = 9;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_CONV} adcr_state_e;
endpackage
